// ==== logic/bdm_data_mem.sv ====
// Functional notes
// RULE1 - Every data location is one byte wide.
// RULE2 - Special-function area is 00H to 7FH, reachable only in sector 0.
// RULE3 - EEPROM control register answers only at 40H of sector 1.
// RULE4 - Addressing starts at 00H with the first special-function location.
// RULE5 - 64 bytes of general RAM sit at 80H to BFH of sector 0.
// RULE6 - General RAM is read/write and supports single-bit set and clear.
// RULE7 - Unused special-function addresses read 00H.
// RULE8 - Read-only special-function registers ignore writes but still read back.
// RULE9 - Indirect ports redirect to the paired pointer target; they hold no storage.
// RULE10 - The first indirect port always resolves inside sector 0.
// RULE11 - Other two ports take offset from pointer low, sector from pointer high.
// RULE12 - An indirect port reached as target reads 00H and ignores writes.
// RULE13 - Five pointer bytes are real read/write/bit-operable registers.
// RULE14 - Extended direct accesses carry a sector number above the offset.
// RULE15 - Sector digit one above an offset selects that offset in sector 1.
// RULE16 - Unimplemented sectors or addresses read zero and ignore writes.
`timescale 1ns/1ps
`include "bdm_defs.svh"

module bdm_data_mem import bdm_pkg::*; #(
    parameter int NUM_SECTORS = `BDM_NUM_SECTORS,
    parameter int RAM_DEPTH = `BDM_RAM_DEPTH
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [1:0] req_op,
    input wire logic req_ext,
    input wire logic [7:0] req_sector,
    input wire logic [7:0] req_offset,
    input wire logic [7:0] req_wdata,
    input wire logic [2:0] req_bit,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic sfr_rd,
    output logic sfr_wr,
    output logic [7:0] sfr_addr,
    output logic sfr_sector1,
    output logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_ro
);

    // Every check runs on the core clock and is muted while reset is held
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    ////////////////////////////////////////////////////////////////////////////
    // Request acceptance and address resolution

    bdm_byte_t ptr_reg [`BDM_NUM_PTRS];
    logic ready_reg;
    logic accept;
    bdm_loc_s loc_dir;
    bdm_loc_s loc_res;
    bdm_byte_t dir_sector;

    logic s1_valid_reg;
    bdm_loc_s s1_loc_reg;
    bdm_op_e s1_op_reg;
    bdm_byte_t s1_wdata_reg;
    logic [2:0] s1_bit_reg;

    assign accept = req_valid && ready_reg;
    // Plain direct accesses stay in sector 0; only extended ones carry a sector
    assign dir_sector = req_ext ? req_sector : 8'h00; // RULE14

    always_comb begin
        loc_dir = bdm_decode(dir_sector, req_offset, 8'(NUM_SECTORS)); // RULE2 RULE3 RULE4 RULE15
        loc_res = loc_dir;
        if (loc_dir.tgt == BDM_TGT_IND) begin // RULE9
            case (loc_dir.offset)
                `BDM_ADDR_IND0: loc_res = bdm_decode(8'h00, ptr_reg[0],
                                                     8'(NUM_SECTORS)); // RULE10
                `BDM_ADDR_INDA: loc_res = bdm_decode(ptr_reg[2], ptr_reg[1],
                                                     8'(NUM_SECTORS)); // RULE11
                default: loc_res = bdm_decode(ptr_reg[4], ptr_reg[3],
                                              8'(NUM_SECTORS)); // RULE11
            endcase
            // A pointer aimed back at a port finds nothing there
            if (loc_res.tgt == BDM_TGT_IND) begin
                loc_res.tgt = BDM_TGT_NONE; // RULE12
            end
        end
    end

    // One request every two cycles keeps a pointer update ahead of the next resolve
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ready_reg <= 1'b1;
        end else begin
            ready_reg <= !accept;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s1_valid_reg <= 1'b0;
            s1_loc_reg <= '{tgt: BDM_TGT_NONE, sector: 8'h00, offset: 8'h00};
            s1_op_reg <= BDM_OP_READ;
            s1_wdata_reg <= `BDM_ZERO;
            s1_bit_reg <= 3'h0;
        end else begin
            s1_valid_reg <= accept;
            if (accept) begin
                s1_loc_reg <= loc_res;
                s1_op_reg <= bdm_op_e'(req_op);
                s1_wdata_reg <= req_wdata;
                s1_bit_reg <= req_bit;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // External special-function strobes

    logic sfr_rd_reg;
    logic sfr_wr_reg;
    bdm_byte_t sfr_addr_reg;
    logic sfr_sector1_reg;
    bdm_byte_t sfr_wdata_reg;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            sfr_rd_reg <= 1'b0;
            sfr_addr_reg <= `BDM_ZERO;
            sfr_sector1_reg <= 1'b0;
        end else begin
            sfr_rd_reg <= accept && (loc_res.tgt == BDM_TGT_SFR);
            if (accept && loc_res.tgt == BDM_TGT_SFR) begin
                sfr_addr_reg <= loc_res.offset;
                sfr_sector1_reg <= (loc_res.sector == `BDM_EEC_SECTOR); // RULE3
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data phase: fetch old byte, merge, write back

    bdm_ram_if ram_bus ();
    bdm_byte_t old_val;
    bdm_byte_t new_val;
    bdm_byte_t bit_mask;
    logic wr_en;
    logic [2:0] s1_ptr_idx;

    assign s1_ptr_idx = bdm_ptr_idx(s1_loc_reg.offset);
    assign bit_mask = 8'h01 << s1_bit_reg;
    assign wr_en = s1_valid_reg && (s1_op_reg != BDM_OP_READ);

    always_comb begin
        case (s1_loc_reg.tgt)
            BDM_TGT_PTR: old_val = ptr_reg[s1_ptr_idx]; // RULE13
            BDM_TGT_RAM: old_val = ram_bus.rdata; // RULE5
            BDM_TGT_SFR: old_val = sfr_rdata; // RULE8
            default: old_val = `BDM_ZERO; // RULE7 RULE12 RULE16
        endcase
    end

    always_comb begin
        case (s1_op_reg)
            BDM_OP_WRITE: new_val = s1_wdata_reg;
            BDM_OP_BSET: new_val = old_val | bit_mask; // RULE6
            BDM_OP_BCLR: new_val = old_val & ~bit_mask; // RULE6
            default: new_val = old_val;
        endcase
    end

    assign ram_bus.idx = s1_loc_reg.offset[`BDM_RAM_IDX_W-1:0]; // RULE5
    assign ram_bus.wr = wr_en && (s1_loc_reg.tgt == BDM_TGT_RAM); // RULE6
    assign ram_bus.wdata = new_val; // RULE1

    bdm_gp_ram #(
        .DEPTH(RAM_DEPTH)
    ) u_ram (
        .clk(clk),
        .nrst(nrst),
        .bus(ram_bus.mem)
    );

    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int i = 0; i < `BDM_NUM_PTRS; i++) begin
                ptr_reg[i] <= `BDM_PTR_RESET;
            end
        end else if (wr_en && s1_loc_reg.tgt == BDM_TGT_PTR) begin
            ptr_reg[s1_ptr_idx] <= new_val; // RULE13
        end
    end

    // Read-only registers flag themselves during the read strobe; the write is dropped
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sfr_wr_reg <= 1'b0;
            sfr_wdata_reg <= `BDM_ZERO;
        end else begin
            sfr_wr_reg <= wr_en && (s1_loc_reg.tgt == BDM_TGT_SFR) && !sfr_ro; // RULE8
            if (wr_en && s1_loc_reg.tgt == BDM_TGT_SFR) begin
                sfr_wdata_reg <= new_val;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Response

    logic rsp_valid_reg;
    bdm_byte_t rsp_data_reg;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rsp_valid_reg <= 1'b0;
            rsp_data_reg <= `BDM_ZERO;
        end else begin
            rsp_valid_reg <= s1_valid_reg;
            if (s1_valid_reg) begin
                rsp_data_reg <= old_val;
            end
        end
    end

    assign req_ready = ready_reg;
    assign rsp_valid = rsp_valid_reg;
    assign rsp_data = rsp_data_reg;
    assign sfr_rd = sfr_rd_reg;
    assign sfr_wr = sfr_wr_reg;
    assign sfr_addr = sfr_addr_reg;
    assign sfr_sector1 = sfr_sector1_reg;
    assign sfr_wdata = sfr_wdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    rsp_timing_a: assert property (accept |=> !req_ready ##1 (rsp_valid && req_ready))
        else $error("response not two cycles after accept");

    none_reads_zero_a: assert property (accept && loc_res.tgt == BDM_TGT_NONE // RULE16
        |-> ##2 rsp_data == `BDM_ZERO)
        else $error("unimplemented location did not read zero");

    unused_sfr_a: assert property (accept && !req_ext && req_offset == `BDM_UNUSED_A // RULE7
        |=> !sfr_rd ##1 rsp_data == `BDM_ZERO)
        else $error("unused special location not zero");

    port_no_store_a: assert property (s1_valid_reg |-> s1_loc_reg.tgt != BDM_TGT_IND) // RULE12
        else $error("indirect port reached as storage");

    port0_sector0_a: assert property (accept && !req_ext && req_offset == `BDM_ADDR_IND0 // RULE10
        && loc_res.tgt != BDM_TGT_NONE |-> loc_res.sector == `BDM_ZERO)
        else $error("first indirect port left sector 0");

    // Pair checks look at the live pointer bytes, so a stale pointer copy would show
    port_a_map_a: assert property (accept && !req_ext && req_offset == `BDM_ADDR_INDA // RULE11
        && loc_res.tgt != BDM_TGT_NONE |-> loc_res.sector == ptr_reg[2]
        && loc_res.offset == ptr_reg[1])
        else $error("second indirect port ignored its pointer pair");

    port_b_map_a: assert property (accept && !req_ext && req_offset == `BDM_ADDR_INDB // RULE11
        && loc_res.tgt != BDM_TGT_NONE |-> loc_res.sector == ptr_reg[4]
        && loc_res.offset == ptr_reg[3])
        else $error("third indirect port ignored its pointer pair");

    sfr_window_a: assert property (sfr_rd |-> (!sfr_sector1 && sfr_addr <= `BDM_SFR_LAST) // RULE2
        || (sfr_sector1 && sfr_addr == `BDM_EEC_ADDR))
        else $error("special strobe outside its window");

    plain_no_eec_a: assert property (accept && !req_ext && req_offset == `BDM_EEC_ADDR // RULE3
        |=> !sfr_rd)
        else $error("plain access reached the control register");

    ext_sector1_a: assert property (accept && req_ext && req_sector == `BDM_EEC_SECTOR // RULE15
        && req_offset == `BDM_EEC_ADDR |=> sfr_rd && sfr_sector1 && sfr_addr == `BDM_EEC_ADDR)
        else $error("extended sector 1 access missed control register");

    // The write strobe must follow the read that fetched the old byte and the read-only flag
    wr_after_rd_a: assert property (sfr_wr |-> $past(sfr_rd)) // RULE8
        else $error("special write strobe without its read");

    ram_window_a: assert property (ram_bus.wr |-> s1_loc_reg.sector == `BDM_ZERO // RULE5
        && s1_loc_reg.offset >= `BDM_RAM_FIRST && s1_loc_reg.offset <= `BDM_RAM_LAST)
        else $error("general RAM written outside its window");

    ro_drop_a: assert property (sfr_rd && sfr_ro |=> !sfr_wr) // RULE8
        else $error("write reached a read-only register");

    ptr_update_a: assert property (wr_en && s1_loc_reg.tgt == BDM_TGT_PTR // RULE13
        |=> ptr_reg[$past(s1_ptr_idx)] == $past(new_val))
        else $error("pointer byte not updated");

    bit_clear_a: assert property (ram_bus.wr && s1_op_reg == BDM_OP_BCLR // RULE6
        |-> !ram_bus.wdata[s1_bit_reg] && ((ram_bus.wdata | bit_mask) == (old_val | bit_mask)))
        else $error("bit clear disturbed other bits");

    bit_set_a: assert property (ram_bus.wr && s1_op_reg == BDM_OP_BSET // RULE6
        |-> ram_bus.wdata[s1_bit_reg] && ((ram_bus.wdata & ~bit_mask) == (old_val & ~bit_mask)))
        else $error("bit set disturbed other bits");

    // Main scenarios the bench is expected to reach
    ind_a_cov: cover property (accept && !req_ext && req_offset == `BDM_ADDR_INDA
        && loc_res.tgt == BDM_TGT_RAM ##2 rsp_valid);
    ext_sec0_cov: cover property (accept && req_ext && req_sector == `BDM_ZERO);
    ram_bset_cov: cover property (ram_bus.wr && s1_op_reg == BDM_OP_BSET);
    ro_write_cov: cover property (sfr_rd && sfr_ro && wr_en);
    eec_cov: cover property (sfr_rd && sfr_sector1);

endmodule

// ==== logic/bdm_defs.svh ====
`ifndef BDM_DEFS_SVH
`define BDM_DEFS_SVH

`define BDM_DATA_W 8
`define BDM_ADDR_IND0 8'h00
`define BDM_ADDR_PTR0 8'h01
`define BDM_ADDR_INDA 8'h02
`define BDM_ADDR_PTRA_LO 8'h03
`define BDM_ADDR_PTRA_SEC 8'h04
`define BDM_ADDR_INDB 8'h0c
`define BDM_ADDR_PTRB_LO 8'h0d
`define BDM_ADDR_PTRB_SEC 8'h0e
`define BDM_SFR_FIRST 8'h00
`define BDM_SFR_LAST 8'h7f
`define BDM_SFR_TOP_USED 8'h4c
`define BDM_UNUSED_A 8'h0b
`define BDM_UNUSED_B 8'h3f
`define BDM_EEC_ADDR 8'h40
`define BDM_EEC_SECTOR 8'h01
`define BDM_RAM_FIRST 8'h80
`define BDM_RAM_LAST 8'hbf
`define BDM_RAM_DEPTH 64
`define BDM_RAM_IDX_W 6
`define BDM_NUM_SECTORS 2
`define BDM_NUM_PTRS 5
`define BDM_PTR_RESET 8'h00
`define BDM_RAM_RESET 8'h00
`define BDM_ZERO 8'h00

`endif

// ==== logic/bdm_pkg.sv ====
`include "bdm_defs.svh"

package bdm_pkg;

    typedef logic [`BDM_DATA_W-1:0] bdm_byte_t;

    typedef enum logic [1:0] {
        BDM_OP_READ = 2'h0,
        BDM_OP_WRITE = 2'h1,
        BDM_OP_BSET = 2'h2,
        BDM_OP_BCLR = 2'h3
    } bdm_op_e;

    typedef enum logic [2:0] {
        BDM_TGT_NONE = 3'h0,
        BDM_TGT_IND = 3'h1,
        BDM_TGT_PTR = 3'h2,
        BDM_TGT_RAM = 3'h3,
        BDM_TGT_SFR = 3'h4
    } bdm_tgt_e;

    typedef struct packed {
        bdm_tgt_e tgt;
        bdm_byte_t sector;
        bdm_byte_t offset;
    } bdm_loc_s;

    // Classifies one sector/offset pair; used for the direct and the indirect step
    function automatic bdm_loc_s bdm_decode(input bdm_byte_t sec, input bdm_byte_t off,
                                            input bdm_byte_t nsec);
        bdm_loc_s loc;
        loc.sector = sec;
        loc.offset = off;
        loc.tgt = BDM_TGT_NONE;
        if (sec >= nsec) begin
            loc.tgt = BDM_TGT_NONE;
        end else if (sec == 8'h00) begin
            if (off <= `BDM_SFR_LAST) begin
                case (off)
                    `BDM_ADDR_IND0, `BDM_ADDR_INDA, `BDM_ADDR_INDB: loc.tgt = BDM_TGT_IND;
                    `BDM_ADDR_PTR0, `BDM_ADDR_PTRA_LO, `BDM_ADDR_PTRA_SEC,
                    `BDM_ADDR_PTRB_LO, `BDM_ADDR_PTRB_SEC: loc.tgt = BDM_TGT_PTR;
                    `BDM_UNUSED_A, `BDM_UNUSED_B, `BDM_EEC_ADDR: loc.tgt = BDM_TGT_NONE;
                    default: loc.tgt = (off > `BDM_SFR_TOP_USED) ? BDM_TGT_NONE : BDM_TGT_SFR;
                endcase
            end else if (off <= `BDM_RAM_LAST) begin
                loc.tgt = BDM_TGT_RAM;
            end
        end else if (sec == `BDM_EEC_SECTOR && off == `BDM_EEC_ADDR) begin
            loc.tgt = BDM_TGT_SFR;
        end
        return loc;
    endfunction

    function automatic logic [2:0] bdm_ptr_idx(input bdm_byte_t off);
        case (off)
            `BDM_ADDR_PTR0: bdm_ptr_idx = 3'h0;
            `BDM_ADDR_PTRA_LO: bdm_ptr_idx = 3'h1;
            `BDM_ADDR_PTRA_SEC: bdm_ptr_idx = 3'h2;
            `BDM_ADDR_PTRB_LO: bdm_ptr_idx = 3'h3;
            default: bdm_ptr_idx = 3'h4;
        endcase
    endfunction

endpackage

// ==== logic/bdm_ram_if.sv ====
`timescale 1ns/1ps
`include "bdm_defs.svh"

interface bdm_ram_if;
    logic [`BDM_RAM_IDX_W-1:0] idx;
    logic wr;
    logic [`BDM_DATA_W-1:0] wdata;
    logic [`BDM_DATA_W-1:0] rdata;
    modport ctrl (output idx, output wr, output wdata, input rdata);
    modport mem (input idx, input wr, input wdata, output rdata);
endinterface

// ==== logic/bdm_gp_ram.sv ====
`timescale 1ns/1ps
`include "bdm_defs.svh"

module bdm_gp_ram import bdm_pkg::*; #(
    parameter int DEPTH = `BDM_RAM_DEPTH
) (
    input wire logic clk,
    input wire logic nrst,
    bdm_ram_if.mem bus
);
    bdm_byte_t mem_reg [DEPTH];

    // Whole-byte writes only; bit operations are merged upstream
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= `BDM_RAM_RESET;
            end
        end else if (bus.wr) begin
            mem_reg[bus.idx] <= bus.wdata; // RULE6
        end
    end

    assign bus.rdata = mem_reg[bus.idx];

    ram_store_a: assert property (@(posedge clk) disable iff (!nrst) // RULE6
        bus.wr |=> mem_reg[$past(bus.idx)] == $past(bus.wdata))
        else $error("general RAM byte not stored");

endmodule

// ==== test/bdm_sfr_model.sv ====
`timescale 1ns/1ps

module bdm_sfr_model #(
    parameter logic [7:0] RO_ADDR = 8'h4c
) (
    input wire logic clk,
    input wire logic sfr_rd,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_sector1,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_ro
);
    logic [7:0] regs [0:127];
    logic [7:0] eec_reg;
    logic [7:0] cur;

    initial begin
        for (int i = 0; i < 128; i++) begin
            regs[i] = 8'(i) ^ 8'h5a;
        end
        eec_reg = 8'h00;
    end

    assign cur = sfr_sector1 ? eec_reg : regs[sfr_addr[6:0]];
    // Not selected: inverse, so a stale sample never looks like good data
    assign sfr_rdata = sfr_rd ? cur : ~cur;
    assign sfr_ro = sfr_rd & ~sfr_sector1 & (sfr_addr == RO_ADDR);

    // Stores even read-only writes, so a stray strobe shows on read-back
    always @(posedge clk) begin
        if (sfr_wr && sfr_sector1) begin
            eec_reg <= sfr_wdata;
        end else if (sfr_wr) begin
            regs[sfr_addr[6:0]] <= sfr_wdata;
        end
    end
endmodule

// ==== test/bdm_data_mem_tb_top.sv ====
`timescale 1ns/1ps

module bdm_data_mem_tb_top;
    typedef struct packed {
        logic [1:0] op;
        logic [7:0] sec;
        logic [7:0] off;
        logic [7:0] wd;
        logic [7:0] ex;
    } bdm_row_s;

    logic clk, nrst, req_valid, req_ready, req_ext, rsp_valid;
    logic sfr_rd, sfr_wr, sfr_sector1, sfr_ro;
    logic [1:0] req_op;
    logic [2:0] req_bit;
    logic [7:0] req_sector, req_offset, req_wdata, rsp_data;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, got;
    int mismatches = 0;
    int samples_checked = 0;

    // Op: 0 read, 1 write, 2 set, 3 clear; bit index is wd[2:0]; ex is the old byte
    bdm_row_s rows [0:45] = '{
        '{2'h1, 8'h00, 8'h80, 8'ha5, 8'h00}, '{2'h2, 8'h00, 8'h80, 8'h01, 8'ha5},
        '{2'h3, 8'h00, 8'h80, 8'h00, 8'ha7}, '{2'h0, 8'h00, 8'h80, 8'h00, 8'ha6},
        '{2'h1, 8'h00, 8'hbf, 8'hff, 8'h00}, '{2'h0, 8'h00, 8'hbf, 8'h00, 8'hff},
        '{2'h1, 8'h00, 8'hc0, 8'h77, 8'h00}, '{2'h0, 8'h00, 8'hc0, 8'h00, 8'h00},
        '{2'h1, 8'h00, 8'h3f, 8'hff, 8'h00}, '{2'h0, 8'h00, 8'h3f, 8'h00, 8'h00},
        '{2'h0, 8'h00, 8'h0b, 8'h00, 8'h00}, '{2'h0, 8'h00, 8'h7f, 8'h00, 8'h00},
        '{2'h1, 8'h00, 8'h40, 8'h11, 8'h00}, '{2'h0, 8'h00, 8'h40, 8'h00, 8'h00},
        '{2'h1, 8'h01, 8'h40, 8'h5e, 8'h00}, '{2'h0, 8'h01, 8'h40, 8'h00, 8'h5e},
        '{2'h0, 8'h01, 8'h41, 8'h00, 8'h00}, '{2'h0, 8'h01, 8'h80, 8'h00, 8'h00},
        '{2'h0, 8'h02, 8'h80, 8'h00, 8'h00}, '{2'h0, 8'h00, 8'h10, 8'h00, 8'h4a},
        '{2'h1, 8'h00, 8'h10, 8'hc3, 8'h4a}, '{2'h2, 8'h00, 8'h10, 8'h02, 8'hc3},
        '{2'h0, 8'h00, 8'h10, 8'h00, 8'hc7}, '{2'h1, 8'h00, 8'h4c, 8'h00, 8'h16},
        '{2'h0, 8'h00, 8'h4c, 8'h00, 8'h16}, '{2'h1, 8'h00, 8'h01, 8'h82, 8'h00},
        '{2'h1, 8'h00, 8'h00, 8'h99, 8'h00}, '{2'h0, 8'h00, 8'h82, 8'h00, 8'h99},
        '{2'h1, 8'h00, 8'h03, 8'h40, 8'h00}, '{2'h1, 8'h00, 8'h04, 8'h01, 8'h00},
        '{2'h0, 8'h00, 8'h02, 8'h00, 8'h5e}, '{2'h1, 8'h00, 8'h02, 8'he1, 8'h5e},
        '{2'h0, 8'h01, 8'h40, 8'h00, 8'he1}, '{2'h1, 8'h00, 8'h0d, 8'h80, 8'h00},
        '{2'h0, 8'h00, 8'h0c, 8'h00, 8'ha6}, '{2'h3, 8'h00, 8'h0c, 8'h07, 8'ha6},
        '{2'h0, 8'h00, 8'h80, 8'h00, 8'h26}, '{2'h1, 8'h00, 8'h01, 8'h40, 8'h82},
        '{2'h0, 8'h00, 8'h00, 8'h00, 8'h00}, '{2'h1, 8'h00, 8'h01, 8'h02, 8'h40},
        '{2'h0, 8'h00, 8'h00, 8'h00, 8'h00}, '{2'h1, 8'h00, 8'h00, 8'h55, 8'h00},
        '{2'h0, 8'h01, 8'h40, 8'h00, 8'he1}, '{2'h2, 8'h00, 8'h01, 8'h00, 8'h02},
        '{2'h0, 8'h00, 8'h01, 8'h00, 8'h03}, '{2'h0, 8'h00, 8'h03, 8'h00, 8'h40}
    };

    bdm_data_mem #(.NUM_SECTORS(2), .RAM_DEPTH(64)) bdm_data_mem_i (
        .clk(clk), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready),
        .req_op(req_op), .req_ext(req_ext), .req_sector(req_sector),
        .req_offset(req_offset), .req_wdata(req_wdata), .req_bit(req_bit),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr),
        .sfr_addr(sfr_addr), .sfr_sector1(sfr_sector1), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .sfr_ro(sfr_ro)
    );

    bdm_sfr_model bdm_sfr_model_i (
        .clk(clk), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
        .sfr_sector1(sfr_sector1), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .sfr_ro(sfr_ro)
    );

    ////////////////////////////////////////////////////////////////////////////////

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: byte %h, wanted %h", $time, g, e);
        end
    endtask

    task automatic stall(input string what);
        mismatches++;
        $display("unexpected at %0t: no %s", $time, what);
        summarize();
    endtask

    // Called at a falling edge; returns at the falling edge that shows the answer
    task automatic xfer(input logic [1:0] op, input logic ext, input logic [7:0] sec,
                        input logic [7:0] off, input logic [7:0] wd, output logic [7:0] rd);
        int n;
        n = 0;
        req_valid = 1'b1;
        req_op = op;
        req_ext = ext;
        req_sector = sec;
        req_offset = off;
        req_wdata = wd;
        req_bit = wd[2:0];
        while (req_ready !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        if (req_ready !== 1'b1) stall("ready");
        @(negedge clk);
        req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        if (rsp_valid !== 1'b1) stall("response");
        rd = rsp_data;
    endtask

    ////////////////////////////////////////////////////////////////////////////////

    initial begin
        nrst = 1'b0;
        req_valid = 1'b0;
        req_op = 2'h0;
        req_ext = 1'b0;
        req_sector = 8'h00;
        req_offset = 8'h00;
        req_wdata = 8'h00;
        req_bit = 3'h0;
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        chk_byte({req_ready, rsp_valid, sfr_rd, sfr_wr, sfr_sector1, 3'h0}, 8'h80);
        chk_byte(rsp_data | sfr_addr | sfr_wdata, 8'h00);
        // Rows run back to back, one request every two cycles, each after the last answer
        foreach (rows[i]) begin
            xfer(rows[i].op, rows[i].sec != 8'h00, rows[i].sec, rows[i].off, rows[i].wd, got);
            chk_byte(got, rows[i].ex);
        end
        // Second reset in mid-run: internal storage clears, the far bank keeps its value
        nrst = 1'b0;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        chk_byte({req_ready, rsp_valid, sfr_rd, sfr_wr, sfr_sector1, 3'h0}, 8'h80);
        chk_byte(rsp_data | sfr_addr | sfr_wdata, 8'h00);
        xfer(2'h0, 1'b0, 8'h00, 8'h80, 8'h00, got);
        chk_byte(got, 8'h00);
        xfer(2'h0, 1'b0, 8'h00, 8'h01, 8'h00, got);
        chk_byte(got, 8'h00);
        xfer(2'h0, 1'b0, 8'h00, 8'h00, 8'h00, got);
        chk_byte(got, 8'h00);
        xfer(2'h0, 1'b0, 8'h00, 8'h10, 8'h00, got);
        chk_byte(got, 8'hc7);
        // Second port aimed at sector 0 RAM, then read back by an extended sector-0 access
        xfer(2'h1, 1'b0, 8'h00, 8'h03, 8'h85, got);
        chk_byte(got, 8'h00);
        xfer(2'h2, 1'b0, 8'h00, 8'h02, 8'h03, got);
        chk_byte(got, 8'h00);
        xfer(2'h0, 1'b1, 8'h00, 8'h85, 8'h00, got);
        chk_byte(got, 8'h08);
        // A plain access ignores the sector field, so 40H is the unused sector-0 slot
        xfer(2'h0, 1'b0, 8'h01, 8'h40, 8'h00, got);
        chk_byte(got, 8'h00);
        summarize();
    end
endmodule
